// file: fpt_deadtime.sv
// Dead time generator for one complementary output pair.
`timescale 1ns/1ps
module fpt_deadtime (
	input wire logic mclk, // System clock.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic tick, // Timer tick.
	input wire logic dt_tick, // Prescaled dead time tick.
	input wire logic wave, // Waveform output.
	input wire logic compl_en, // Complementary mode with dead time.
	input wire logic invert, // Invert both outputs, only while compl_en is set.
	input wire logic [3:0] rise_cnt, // Dead time before the true output rises.
	input wire logic [3:0] fall_cnt, // Dead time before the inverse rises.
	output logic out_p_q, // True compare output.
	output logic out_n_q // Inverse compare output.
);
	logic wave_q;
	logic [3:0] cnt_q;
	logic p_raw, n_raw;
	// Edge detection and the delayed copy run on the timer tick.
	always_ff @(posedge mclk) begin
		if (reset) begin
			wave_q <= 1'b0;
		end else if (tick) begin
			wave_q <= wave;
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			cnt_q <= 4'h0;
		end else if (tick && wave != wave_q) begin
			cnt_q <= wave ? rise_cnt : fall_cnt;
		end else if (dt_tick && cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
	always_comb begin
		if (compl_en) begin
			// Only the rising side is held back until the counter is zero.
			p_raw = wave_q && cnt_q == 4'h0 && wave == wave_q;
			n_raw = !wave_q && cnt_q == 4'h0 && wave == wave_q;
		end else begin
			p_raw = wave_q;
			n_raw = 1'b0;
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			out_p_q <= 1'b0;
			out_n_q <= 1'b0;
		end else begin
			out_p_q <= p_raw ^ (invert & compl_en);
			out_n_q <= n_raw ^ (invert & compl_en);
		end
	end
endmodule // fpt_deadtime

// file: fpt_gate_model.sv
// Model of a power switch leg driven by one complementary output pair.
`timescale 1ns/1ps
module fpt_gate_model (
	input wire logic mclk, // Clock that times the gaps.
	input wire logic clr, // Restart the measurement.
	input wire logic inv, // Gates are active low.
	input wire logic gate_hi, // High side gate.
	input wire logic gate_lo, // Low side gate.
	output int shoot_cnt, // Cycles with both switches on.
	output int on_cnt, // Switch turn-on events.
	output int min_gap // Shortest all-off gap before a turn-on.
);
	logic hi_on, lo_on;
	logic hi_was = 1'b0;
	logic lo_was = 1'b0;
	int gap;
	assign hi_on = gate_hi ^ inv;
	assign lo_on = gate_lo ^ inv;
	always @(posedge mclk) begin
		if (clr) begin
			{shoot_cnt, on_cnt, min_gap, gap} <= {32'd0, 32'd0, 32'd99, 32'd99};
		end else begin
			if (hi_on && lo_on)
				shoot_cnt <= shoot_cnt + 1;
			gap <= (hi_on || lo_on) ? 0 : gap + 1;
			if ((hi_on && !hi_was) || (lo_on && !lo_was)) begin
				on_cnt <= on_cnt + 1;
				min_gap <= (gap < min_gap) ? gap : min_gap;
			end
		end
		hi_was <= hi_on;
		lo_was <= lo_on;
	end
endmodule // fpt_gate_model

// file: fpt_pkg.sv
// Package of constants and types for the fast PWM timer core.
package fpt_pkg;
	localparam int CNT_W = 10;
	localparam int ADDR_W = 4;
	// Register offsets.
	localparam logic [3:0] REG_CTRL_A = 4'h0;
	localparam logic [3:0] REG_CTRL_B = 4'h1;
	localparam logic [3:0] REG_CTRL_C = 4'h2;
	localparam logic [3:0] REG_PLL = 4'h3;
	localparam logic [3:0] REG_COUNT = 4'h4;
	localparam logic [3:0] REG_CMP_A = 4'h5;
	localparam logic [3:0] REG_CMP_B = 4'h6;
	localparam logic [3:0] REG_TOP = 4'h7;
	localparam logic [3:0] REG_CMP_D = 4'h8;
	localparam logic [3:0] REG_FLAGS = 4'h9;
	localparam logic [3:0] REG_DEADTIME = 4'hA;
	localparam logic [3:0] REG_FORCE = 4'hB;
	// Control B field positions.
	localparam int CB_CS_LSB = 0;
	localparam int CB_PSR_BIT = 4;
	localparam int CB_DTPS_LSB = 5;
	// Control A field positions.
	localparam int CA_PWMA_BIT = 0;
	localparam int CA_PWMB_BIT = 1;
	localparam int CA_WGM_LSB = 2;
	localparam int CA_INV_BIT = 4;
	// Control C: output mode fields, two bits per channel A, B, D.
	localparam int CC_COM_LSB = 0;
	// PLL register bits.
	localparam int PL_ACLK_BIT = 0;
	localparam int PL_LSM_BIT = 1;
	localparam int PL_LOCK_BIT = 2;
	// Flag register bits.
	localparam int FL_OVF_BIT = 0;
	localparam int FL_MA_BIT = 1;
	// Reset values.
	localparam logic [CNT_W-1:0] TOP_RESET = 10'h0FF;
	localparam logic [7:0] DT_RESET = 8'h00;
	// Fast clock rates in MHz.
	localparam int FAST_MHZ = 64;
	localparam int SLOW_MHZ = 32;
	localparam int PRE_W = 14;
	localparam logic [1:0] COM_COMPL = 2'h1;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	typedef enum logic [1:0] {
		FPT_FAST = 2'b00,
		FPT_PFC = 2'b01,
		FPT_WGM2 = 2'b10,
		FPT_WGM3 = 2'b11
	} fpt_wgm_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} fpt_bus_t;
endpackage

// file: fpt_timer.sv
// Fast PWM timer core: prescaler, counter, compare units, dead time.
// What this block does
// - Async clock enable picks the fast peripheral clock, else system timebase.
// - Prescaler offers undivided to divide by 16384, plus stopped.
// - Fast peripheral clock is 64 MHz, 32 MHz with low speed select.
// - Writing one to the prescaler reset bit restarts the prescaler.
// - Each tick clears, increments or decrements the counter per mode.
// - Clock select zero stops counting; counter stays readable and writable.
// - A CPU counter write beats any count in the same cycle.
// - Mode field and PWM enables pick counting; overflow flag set per mode.
// - Equality with A, B or D sets that match flag next tick.
// - Match flags clear on service or by writing one.
// - PWM modes buffer compare values, updated at top or bottom.
// - Compare reads return the most recently written value.
// - Force strobe acts on the waveform output only, in non-PWM modes.
// - A counter write blocks compare matches in the next tick.
// - Waveforms keep their level when the mode changes.
// - Output mode bits act at once, unbuffered.
// - Three dead time generators make complementary pairs in PWM modes with output mode 01.
// - Dead time prescaler divides the source by 1, 2, 4 or 8.
// - Edges load rise or fall nibble; rising side waits for zero.
// - Outputs lag the waveform by at least one tick; complementary turn-off lags by one clock.
// - Inversion bit inverts both outputs in complementary mode only, high during dead time.
`timescale 1ns/1ps
module fpt_timer #(
	parameter int CW = fpt_pkg::CNT_W
) (
	input wire logic mclk, // System clock, 200 MHz.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic fast_peripheral_clock, // PLL clock pin, sampled.
	input wire logic pll_lock_flag, // PLL lock status pin.
	input wire logic int_ack_ovf, // Overflow interrupt serviced.
	input wire logic [2:0] int_ack_match, // Match interrupts serviced A, B, D.
	input wire fpt_pkg::fpt_bus_t bus, // Register request.
	output logic [7:0] rdata_q, // Read data, one cycle after the strobe.
	output logic [2:0] out_p_q, // True compare outputs A, B, D.
	output logic [2:0] out_n_q, // Inverse compare outputs A, B, D.
	output logic [3:0] flags_q // Overflow and match flags.
);
	import fpt_pkg::*;

	logic [7:0] ctrl_a_q, ctrl_b_q, ctrl_c_q, dt_q;
	logic async_clock_enable_q, low_speed_select_q;
	logic [CW-1:0] count_q;
	logic [CW-1:0] buf_q [4];
	logic [CW-1:0] work_q [4];
	logic [2:0] pend_q;
	logic [2:0] wave_q;
	logic [2:0] match_flag_q;
	logic overflow_flag_q;
	logic dir_down_q;
	logic block_q;
	logic [2:0] pck_s;
	logic lsm_div_q;
	logic [PRE_W-1:0] pre_q;
	logic [2:0] dtp_q;
	logic src_tick, tick, dt_tick, pwm_on, cnt_wr, at_top, at_bot;
	logic [3:0] cs;
	logic [2:0] chan_match;
	logic [2:0] force_wr;
	fpt_wgm_t wgm;

	assign cs = ctrl_b_q[CB_CS_LSB +: 4];
	assign wgm = fpt_wgm_t'(ctrl_a_q[CA_WGM_LSB +: 2]);
	assign pwm_on = ctrl_a_q[CA_PWMA_BIT] | ctrl_a_q[CA_PWMB_BIT];
	assign cnt_wr = bus.wr && bus.addr == REG_COUNT;
	assign at_top = count_q == work_q[2];
	assign at_bot = count_q == '0;
	assign force_wr = (bus.wr && bus.addr == REG_FORCE) ? bus.wdata[2:0] : 3'h0;

	// Fast clock pin passes three flops; an edge counts when stage 2 is high and stage 3 still low.
	always_ff @(posedge mclk) begin
		if (reset) begin
			pck_s <= 3'h0;
		end else begin
			pck_s <= {pck_s[1:0], fast_peripheral_clock};
		end
	end

	// Low speed select halves the fast peripheral clock rate.
	always_ff @(posedge mclk) begin
		if (reset) begin
			lsm_div_q <= 1'b0;
		end else if (!low_speed_select_q) begin
			lsm_div_q <= 1'b0;
		end else if (!pck_s[2] && pck_s[1]) begin
			lsm_div_q <= ~lsm_div_q;
		end
	end

	always_comb begin
		if (async_clock_enable_q) begin
			src_tick = !pck_s[2] && pck_s[1] &&
				(!low_speed_select_q || lsm_div_q);
		end else begin
			src_tick = 1'b1;
		end
	end

	// Prescaler counter; the reset bit restarts it.
	always_ff @(posedge mclk) begin
		if (reset) begin
			pre_q <= '0;
		end else if (bus.wr && bus.addr == REG_CTRL_B &&
				bus.wdata[CB_PSR_BIT]) begin
			pre_q <= '0;
		end else if (src_tick) begin
			pre_q <= pre_q + 1'b1;
		end
	end

	// Setting n selects the source divided by 2^(n-1), up to 16384.
	always_comb begin
		if (cs == 4'h0) begin
			tick = 1'b0;
		end else if (cs == 4'h1) begin
			tick = src_tick;
		end else begin
			tick = src_tick &&
				(pre_q & ((PRE_W'(1) << (cs - 4'h1)) - PRE_W'(1))) ==
				((PRE_W'(1) << (cs - 4'h1)) - PRE_W'(1));
		end
	end

	// Dead time prescaler divides the source by 1, 2, 4 or 8.
	always_ff @(posedge mclk) begin
		if (reset) begin
			dtp_q <= 3'h0;
		end else if (src_tick) begin
			dtp_q <= dtp_q + 3'h1;
		end
	end
	always_comb begin
		case (ctrl_b_q[CB_DTPS_LSB +: 2])
			2'h0: dt_tick = src_tick;
			2'h1: dt_tick = src_tick && dtp_q[0];
			2'h2: dt_tick = src_tick && &dtp_q[1:0];
			default: dt_tick = src_tick && &dtp_q;
		endcase
	end

	// Control registers.
	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl_a_q <= 8'h00;
			ctrl_b_q <= 8'h00;
			ctrl_c_q <= 8'h00;
			dt_q <= DT_RESET;
			async_clock_enable_q <= 1'b0;
			low_speed_select_q <= 1'b0;
		end else if (bus.wr) begin
			case (bus.addr)
				REG_CTRL_A: ctrl_a_q <= bus.wdata;
				REG_CTRL_B: ctrl_b_q <= {bus.wdata[7:5], 1'b0, bus.wdata[3:0]};
				REG_CTRL_C: ctrl_c_q <= bus.wdata;
				REG_DEADTIME: dt_q <= bus.wdata;
				REG_PLL: begin
					async_clock_enable_q <= bus.wdata[PL_ACLK_BIT];
					low_speed_select_q <= bus.wdata[PL_LSM_BIT];
				end
				default: ;
			endcase
		end
	end

	// Counter with direction for the dual slope mode.
	always_ff @(posedge mclk) begin
		if (reset) begin
			count_q <= '0;
			dir_down_q <= 1'b0;
		end else if (cnt_wr) begin
			count_q <= CW'(bus.wdata);
		end else if (tick) begin
			if (pwm_on && wgm == FPT_PFC) begin
				if (dir_down_q) begin
					count_q <= count_q - 1'b1;
					if (count_q == CW'(1)) dir_down_q <= 1'b0;
				end else if (at_top) begin
					count_q <= count_q - 1'b1;
					dir_down_q <= 1'b1;
				end else begin
					count_q <= count_q + 1'b1;
				end
			end else if (at_top) begin
				count_q <= '0;
				dir_down_q <= 1'b0;
			end else begin
				count_q <= count_q + 1'b1;
				dir_down_q <= 1'b0;
			end
		end
	end

	// A counter write blocks matches until the next tick has passed.
	always_ff @(posedge mclk) begin
		if (reset) begin
			block_q <= 1'b0;
		end else if (cnt_wr) begin
			block_q <= 1'b1;
		end else if (tick) begin
			block_q <= 1'b0;
		end
	end

	// Overflow flag: set at bottom per mode; set wins over clear.
	always_ff @(posedge mclk) begin
		if (reset) begin
			overflow_flag_q <= 1'b0;
		end else if (tick && !cnt_wr && (
				(!(pwm_on && wgm == FPT_PFC) && at_top) ||
				(pwm_on && wgm == FPT_PFC && dir_down_q &&
				count_q == CW'(1)))) begin
			overflow_flag_q <= 1'b1;
		end else if (int_ack_ovf || (bus.wr && bus.addr == REG_FLAGS &&
				bus.wdata[FL_OVF_BIT])) begin
			overflow_flag_q <= 1'b0;
		end
	end

	// Compare channels A, B, top, D; index 2 is the top value.
	for (genvar i = 0; i < 4; i++) begin : g_cmp
		logic [3:0] off;
		assign off = REG_CMP_A + 4'(i);
		always_ff @(posedge mclk) begin
			if (reset) begin
				buf_q[i] <= (i == 2) ? TOP_RESET : '0;
				work_q[i] <= (i == 2) ? TOP_RESET : '0;
			end else begin
				if (bus.wr && bus.addr == off) begin
					buf_q[i] <= CW'(bus.wdata);
				end
				if (!pwm_on && bus.wr && bus.addr == off) begin
					work_q[i] <= CW'(bus.wdata);
				end else if (pwm_on && tick && (at_top || at_bot)) begin
					work_q[i] <= buf_q[i];
				end
			end
		end
	end

	// Pending buffered writes, visible for status only.
	always_ff @(posedge mclk) begin
		if (reset) begin
			pend_q <= 3'h0;
		end else if (pwm_on && tick && (at_top || at_bot)) begin
			pend_q <= 3'h0;
		end else if (pwm_on && bus.wr) begin
			pend_q <= pend_q | {bus.addr == REG_CMP_D,
				bus.addr == REG_CMP_B, bus.addr == REG_CMP_A};
		end
	end

	// Match detection, flags and waveform per output channel.
	for (genvar c = 0; c < 3; c++) begin : g_chan
		localparam int WI = (c == 2) ? 3 : c;
		logic [1:0] com;
		assign com = ctrl_c_q[CC_COM_LSB + 2*c +: 2];
		assign chan_match[c] = count_q == work_q[WI] && !block_q;
		always_ff @(posedge mclk) begin
			if (reset) begin
				match_flag_q[c] <= 1'b0;
			end else if (tick && !cnt_wr && chan_match[c]) begin
				match_flag_q[c] <= 1'b1;
			end else if (int_ack_match[c] || (bus.wr &&
					bus.addr == REG_FLAGS && bus.wdata[FL_MA_BIT + c])) begin
				match_flag_q[c] <= 1'b0;
			end
		end
		// Waveform keeps its level across mode changes.
		always_ff @(posedge mclk) begin
			if (reset) begin
				wave_q[c] <= 1'b0;
			end else if (!pwm_on && (force_wr[c] ||
					(tick && chan_match[c]))) begin
				case (com)
					COM_TOGGLE: wave_q[c] <= ~wave_q[c];
					COM_CLEAR: wave_q[c] <= 1'b0;
					COM_SET: wave_q[c] <= 1'b1;
					default: wave_q[c] <= wave_q[c];
				endcase
			end else if (pwm_on && tick && com != 2'h0) begin
				if (chan_match[c]) begin
					wave_q[c] <= (com == COM_SET);
				end else if (at_bot) begin
					wave_q[c] <= (com != COM_SET);
				end
			end
		end
		fpt_deadtime u_dt (
			.mclk(mclk),
			.reset(reset),
			.tick(tick),
			.dt_tick(dt_tick),
			.wave(wave_q[c]),
			.compl_en(pwm_on && com == COM_COMPL),
			.invert(ctrl_a_q[CA_INV_BIT]),
			.rise_cnt(dt_q[7:4]),
			.fall_cnt(dt_q[3:0]),
			.out_p_q(out_p_q[c]),
			.out_n_q(out_n_q[c])
		);
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			flags_q <= 4'h0;
		end else begin
			flags_q <= {match_flag_q, overflow_flag_q};
		end
	end

	// Read port; compare reads return the buffered value.
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				REG_CTRL_A: rdata_q <= ctrl_a_q;
				REG_CTRL_B: rdata_q <= ctrl_b_q;
				REG_CTRL_C: rdata_q <= ctrl_c_q;
				REG_PLL: rdata_q <= {5'h00, pll_lock_flag,
					low_speed_select_q, async_clock_enable_q};
				REG_COUNT: rdata_q <= count_q[7:0];
				REG_CMP_A: rdata_q <= buf_q[0][7:0];
				REG_CMP_B: rdata_q <= buf_q[1][7:0];
				REG_TOP: rdata_q <= buf_q[2][7:0];
				REG_CMP_D: rdata_q <= buf_q[3][7:0];
				REG_FLAGS: rdata_q <= {1'b0, pend_q,
					match_flag_q, overflow_flag_q};
				REG_DEADTIME: rdata_q <= dt_q;
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end
endmodule // fpt_timer

// file: fpt_timer_sva.sv
// Port-level assertion checker for the fast PWM timer core.
`timescale 1ns/1ps
module fpt_timer_sva #(
	parameter int CW = fpt_pkg::CNT_W
) (
	input wire logic mclk, // System clock.
	input wire logic reset, // Synchronous reset.
	input wire logic fast_peripheral_clock, // Fast clock pin.
	input wire logic pll_lock_flag, // Lock status pin.
	input wire logic int_ack_ovf, // Overflow serviced.
	input wire logic [2:0] int_ack_match, // Matches serviced.
	input wire fpt_pkg::fpt_bus_t bus, // Register request.
	input wire logic [7:0] rdata_q, // Read data.
	input wire logic [2:0] out_p_q, // True outputs.
	input wire logic [2:0] out_n_q, // Inverse outputs.
	input wire logic [3:0] flags_q // Flags.
);
	import fpt_pkg::*;
	logic [7:0] ca_q, cb_q, cc_q, cmpa_q, cnt_q;
	logic cmpa_v_q, cnt_v_q;
	logic [2:0] settle_q;
	logic [3:0] stop_q;
	logic compl_a;
	default clocking dcb @(posedge mclk); endclocking
	default disable iff (reset);
	// Shadow of the control, compare A and counter writes seen on the bus.
	always_ff @(posedge mclk) begin
		if (reset) begin
			{ca_q, cb_q, cc_q, cmpa_q, cnt_q, cmpa_v_q, cnt_v_q} <= '0;
		end else if (bus.wr) begin
			case (bus.addr)
				REG_CTRL_A: ca_q <= bus.wdata;
				REG_CTRL_B: cb_q <= bus.wdata;
				REG_CTRL_C: cc_q <= bus.wdata;
				REG_CMP_A: {cmpa_v_q, cmpa_q} <= {1'b1, bus.wdata};
				REG_COUNT: {cnt_v_q, cnt_q} <= {1'b1, bus.wdata};
				default: ;
			endcase
		end else if (cb_q[3:0] != 4'h0) begin
			cnt_v_q <= 1'b0;
		end
	end
	// Mode changes get a few cycles before the pair is judged.
	always_ff @(posedge mclk) begin
		if (reset || (bus.wr && (bus.addr == REG_CTRL_A ||
			bus.addr == REG_CTRL_C)))
			settle_q <= 3'h0;
		else if (settle_q != 3'h7)
			settle_q <= settle_q + 3'h1;
	end
	// Counts cycles spent stopped, so late synchronised ticks are over.
	always_ff @(posedge mclk) begin
		if (reset || cb_q[3:0] != 4'h0 || (bus.wr && bus.addr == REG_CTRL_B))
			stop_q <= 4'h0;
		else if (stop_q != 4'hF)
			stop_q <= stop_q + 4'h1;
	end
	assign compl_a = ca_q[CA_PWMA_BIT] && cc_q[1:0] == COM_COMPL &&
		settle_q == 3'h7;
	AST_NO_OVERLAP: assert property (
		compl_a && !ca_q[CA_INV_BIT] |-> !(out_p_q[0] && out_n_q[0]))
		else $error("pair A overlaps");
	AST_INV_NO_LOW: assert property (
		compl_a && ca_q[CA_INV_BIT] |-> (out_p_q[0] || out_n_q[0]))
		else $error("inverted pair A both low");
	AST_CMP_READBACK: assert property (
		bus.rd && bus.addr == REG_CMP_A && cmpa_v_q |=> rdata_q == cmpa_q)
		else $error("compare A read not last written");
	AST_RD_IDLE: assert property (
		!bus.rd |=> rdata_q == 8'h00)
		else $error("read data without read");
	AST_CNT_STOPPED: assert property (
		bus.rd && bus.addr == REG_COUNT && cnt_v_q && cb_q[3:0] == 4'h0
		|=> rdata_q == cnt_q)
		else $error("stopped counter read wrong");
	AST_PSR_READS_ZERO: assert property (
		bus.rd && bus.addr == REG_CTRL_B |=> !rdata_q[CB_PSR_BIT])
		else $error("prescaler reset bit reads one");
	AST_STOP_FLAGS: assert property (
		stop_q == 4'hF && !bus.wr && !int_ack_ovf && int_ack_match == 3'h0 &&
		!$past(bus.wr) && !$past(int_ack_ovf) && $past(int_ack_match) == 3'h0
		|=> $stable(flags_q))
		else $error("flags moved while stopped");
	AST_W1C_MATCH: assert property (
		stop_q == 4'hF && bus.wr && bus.addr == REG_FLAGS &&
		bus.wdata[FL_MA_BIT] |-> ##2 !flags_q[FL_MA_BIT])
		else $error("match A flag not cleared by write");
	AST_ACK_OVF: assert property (
		stop_q == 4'hF && int_ack_ovf |-> ##2 !flags_q[FL_OVF_BIT])
		else $error("overflow flag not cleared by service");
	cover property (compl_a && out_p_q[0]);
	cover property (compl_a && ca_q[CA_INV_BIT] && out_p_q[0] && out_n_q[0]);
	cover property (flags_q[FL_MA_BIT]);
endmodule // fpt_timer_sva

bind fpt_timer fpt_timer_sva #(.CW(CW)) i_sva (.mclk(mclk), .reset(reset),
	.fast_peripheral_clock(fast_peripheral_clock),
	.pll_lock_flag(pll_lock_flag), .int_ack_ovf(int_ack_ovf),
	.int_ack_match(int_ack_match), .bus(bus), .rdata_q(rdata_q),
	.out_p_q(out_p_q), .out_n_q(out_n_q), .flags_q(flags_q));

// file: fpt_timer_tb_top.sv
// Self-checking testbench for the fast PWM timer core.
`timescale 1ns/1ps
module fpt_timer_tb_top;
	import fpt_pkg::*;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic fclk = 1'b0;
	logic lock = 1'b0;
	logic ack_ovf = 1'b0;
	logic [2:0] ack_m = 3'h0;
	fpt_bus_t bus = '0;
	logic [7:0] rdata_q, rv;
	logic [2:0] out_p_q, out_n_q;
	logic [3:0] flags_q;
	logic clr = 1'b1;
	logic inv_b = 1'b0;
	int shoot_cnt, on_cnt, min_gap;
	int bad_count = 0;
	int cmp_count = 0;
	always #2.5 mclk = ~mclk;
	always #7.8125 fclk = ~fclk;
	fpt_timer i_dut (.mclk(mclk), .reset(reset), .fast_peripheral_clock(fclk),
		.pll_lock_flag(lock), .int_ack_ovf(ack_ovf), .int_ack_match(ack_m),
		.bus(bus), .rdata_q(rdata_q), .out_p_q(out_p_q), .out_n_q(out_n_q),
		.flags_q(flags_q));
	fpt_gate_model i_gate (.mclk(mclk), .clr(clr), .inv(inv_b),
		.gate_hi(out_p_q[0]), .gate_lo(out_n_q[0]), .shoot_cnt(shoot_cnt),
		.on_cnt(on_cnt), .min_gap(min_gap));
	task automatic stop_test();
		if (bad_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] got,
		input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk) bus <= '0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge mclk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk) bus <= '0;
		#1 rv = rdata_q;
	endtask
	task automatic ack(input logic o, input logic [2:0] m);
		@(posedge mclk) {ack_ovf, ack_m} <= {o, m};
		@(posedge mclk) {ack_ovf, ack_m} <= 4'h0;
		@(posedge mclk);
		#1;
	endtask
	task automatic t_regs();
		rd(REG_TOP);
		chk("top", rv, TOP_RESET[7:0]);
		rd(REG_DEADTIME);
		chk("deadtime", rv, DT_RESET);
		rd(4'hF);
		chk("unmapped", rv, 8'h00);
		wr(REG_CTRL_B, 8'h10);
		rd(REG_CTRL_B);
		chk("psr", rv, 8'h00);
		wr(REG_COUNT, 8'h37);
		rd(REG_COUNT);
		chk("cnt_wr", rv, 8'h37);
		wt(20);
		rd(REG_COUNT);
		chk("cnt_hold", rv, 8'h37);
	endtask
	// Ticks counted over a fixed window; prescaler phase gives some slack.
	task automatic t_rate(input logic [3:0] cs, input int cyc, input int exp);
		wr(REG_COUNT, 8'h00);
		wr(REG_CTRL_B, {4'h0, cs});
		wt(cyc);
		wr(REG_CTRL_B, 8'h00);
		rd(REG_COUNT);
		chk("rate", 8'(rv + 4 >= exp && rv <= exp + 4), 8'h01);
	endtask
	task automatic t_async();
		lock <= 1'b1;
		rd(REG_PLL);
		chk("lock", rv, 8'h04);
		wr(REG_PLL, 8'h01);
		t_rate(4'h1, 318, 102);
		wr(REG_PLL, 8'h00);
	endtask
	task automatic t_match();
		wr(REG_TOP, 8'h20);
		wr(REG_CMP_A, 8'h10);
		wr(REG_COUNT, 8'h10);
		wr(REG_FLAGS, 8'h0F);
		wr(REG_CTRL_B, 8'h01);
		wr(REG_CTRL_B, 8'h00);
		wt(20);
		chk("blocked", 8'(flags_q[1]), 8'h00);
		wr(REG_CTRL_B, 8'h01);
		wt(100);
		wr(REG_CTRL_B, 8'h00);
		wt(20);
		chk("ovf", 8'(flags_q[0]), 8'h01);
		chk("match_a", 8'(flags_q[1]), 8'h01);
		wr(REG_FLAGS, 8'h02);
		wt(1);
		#1 chk("w1c", 8'(flags_q[1:0]), 8'h01);
		ack(1'b1, 3'h2);
		chk("ack", 8'(flags_q[2:0]), 8'h00);
	endtask
	task automatic t_gate(input logic iv, input int gmin, input int cyc);
		inv_b <= iv;
		wt(20);
		clr <= 1'b0;
		wt(cyc);
		chk("shoot", 8'(shoot_cnt), 8'h00);
		chk("edges", 8'(on_cnt > 4), 8'h01);
		chk("gap", 8'(min_gap >= gmin), 8'h01);
		clr <= 1'b1;
	endtask
	task automatic t_pwm();
		wr(REG_CTRL_A, 8'h01);
		wr(REG_CTRL_B, 8'h01);
		wr(REG_CMP_A, 8'h18);
		rd(REG_CMP_A);
		chk("cmp_buf", rv, 8'h18);
		wr(REG_DEADTIME, 8'h42);
		wr(REG_CTRL_C, 8'h01);
		t_gate(1'b0, 2, 400);
		wr(REG_CTRL_A, 8'h11);
		t_gate(1'b1, 2, 400);
		wr(REG_TOP, 8'h80);
		wr(REG_CMP_A, 8'h40);
		wr(REG_CTRL_B, 8'h61);
		t_gate(1'b1, 8, 1200);
	endtask
	initial begin
		#100000;
		bad_count++;
		stop_test();
	end
	initial begin
		wt(8);
		reset <= 1'b0;
		t_regs();
		for (int cs = 1; cs <= 4; cs++)
			t_rate(4'(cs), 62, 64 >> (cs - 1));
		t_async();
		t_match();
		t_pwm();
		stop_test();
	end
endmodule // fpt_timer_tb_top
